// file: daa_line_side_config_monitor_tb.sv
// self-checking bench: control 2 writes, country loads and line sense readout.
// assumes dlc_pkg and the line model are compiled first; one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module daa_line_side_config_monitor_tb;
   import dlc_pkg::*;
   localparam logic [3:0] IDV = 4'h6; // arbitrary identity value
   localparam int LOCK_CYC = 40000; // worst-case lock time of 1 ms at 25 ns
   logic clk, rst_n, c2_we, cfg_we, id_good, loop_on;
   logic [7:0] c2_wd;
   logic [12:0] cfg; // dct[12:11] act ohs rt rz lim vol full par hook mon vsel[0]
   logic [11:0] volt_q, curr_q, volt_raw, curr_raw;
   logic [4:0] mon, mon_data;
   logic [3:0] ls_id;
   logic loop_present, link_en, link_up, id_fail, pwr, cpo, hook_on, drop;
   logic ac_o, ohs_o, rt_o, rz_o, lim_o, vol_o, full_o, dcz_o, pin_o;
   logic [1:0] dct_o;
   dlc_code_t sense;
   int n_fail = 0;
   int n_checks = 0;
   logic [12:0] rows [5] = '{13'h1000, 13'h1840, 13'h0820, 13'h0E00, 13'h1180};
   logic [11:0] vr [5] = '{12'h00B, 12'h00C, 12'h037, 12'h155, 12'h3E8};
   logic [4:0] ve [5] = '{5'h00, 5'h01, 5'h05, 5'h1F, 5'h1F};
   logic [11:0] cr [5] = '{12'h00B, 12'h00C, 12'h168, 12'h230, 12'h231};
   logic [4:0] ce [5] = '{5'h00, 5'h01, 5'h1E, 5'h1E, 5'h1F};

   dlc_line_model #(.ID_EXPECT(IDV)) u_dlc_line_model (.clk(clk), .rst_n(rst_n),
      .id_good(id_good), .volt_q(volt_q), .curr_q(curr_q), .loop_on(loop_on), .mon(mon),
      .ls_id(ls_id), .volt_raw(volt_raw), .curr_raw(curr_raw),
      .loop_present(loop_present), .mon_data(mon_data));

   dlc_line_cfg #(.ID_EXPECT(IDV)) u_dlc_line_cfg (.CLK(clk), .RST_N(rst_n),
      .CTRL2_WE(c2_we), .CTRL2_WDATA(c2_wd), .CFG_WE(cfg_we),
      .DC_TERMINATION_SEL(cfg[12:11]), .AC_IMPEDANCE_SELECT(cfg[10]),
      .HOOK_SPEED_SEL(cfg[9]), .RING_THRESHOLD_SEL(cfg[8]), .RINGER_IMPEDANCE_SEL(cfg[7]),
      .CURRENT_CAP_EN(cfg[6]), .LOW_LINE_BOOST(cfg[5]), .HIGH_LEVEL_SELECT(cfg[4]),
      .PARALLEL_IMPEDANCE_SELECT(cfg[3]), .HOOK_SEIZE(cfg[2]),
      .ON_HOOK_MONITOR_EN(cfg[1]), .VOLTAGE_REPORT_SELECT(cfg[0]),
      .LS_ID(ls_id), .LOOP_PRESENT(loop_present), .VOLT_RAW(volt_raw),
      .CURR_RAW(curr_raw), .MON_DATA(mon_data), .LINK_ENABLE(link_en), .LINK_UP(link_up),
      .ID_FAIL(id_fail), .LINE_SIDE_PWR(pwr), .CALL_PROGRESS_OUT(cpo),
      .HOOKSWITCH_ON(hook_on), .DC_TERM_OUT(dct_o), .AC_IMP_OUT(ac_o),
      .HOOK_SPEED_OUT(ohs_o), .RING_THRESH_OUT(rt_o), .RINGER_IMP_OUT(rz_o),
      .CURRENT_CAP_OUT(lim_o), .LOW_BOOST_OUT(vol_o), .FULL_SCALE_HIGH(full_o),
      .DC_IMPEDANCE_HIGH(dcz_o), .TERM_PIN_LOW(pin_o), .LINE_SENSE_VALUE(sense),
      .LINE_DROPOUT_FLAG(drop));

   // compare helper; case inequality so an unknown never matches
   task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // bring-up takes about seven cycles, so nine leaves margin
   task automatic c2_write(input logic [7:0] d);
      @(posedge clk);
      c2_we <= 1'b1;
      c2_wd <= d;
      @(posedge clk);
      c2_we <= 1'b0;
      wait_clk(9);
   endtask
   task automatic cfg_load(input logic [12:0] w);
      @(posedge clk);
      cfg <= w;
      cfg_we <= 1'b1;
      @(posedge clk);
      cfg_we <= 1'b0;
      wait_clk(3);
   endtask
   // model stage, sync flops and sense register all settle inside six cycles
   task automatic line_set(input logic [11:0] v, input logic [11:0] i, input logic lp,
                           input logic [4:0] m);
      @(posedge clk);
      volt_q <= v;
      curr_q <= i;
      loop_on <= lp;
      mon <= m;
      wait_clk(6);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // free-running 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // watchdog: the lock wait plus the sequence need well under fifty thousand cycles
   initial begin
      #(25.0 * 60000);
      n_fail++;
      close_out();
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      c2_we = 1'b0;
      c2_wd = 8'h03;
      cfg_we = 1'b0;
      cfg = 13'h1000;
      id_good = 1'b0;
      volt_q = 12'h000;
      curr_q = 12'h000;
      loop_on = 1'b1;
      mon = 5'h00;
      wait_clk(8);
      rst_n <= 1'b1;
      chk("link_en", link_en, 0);
      chk("pwr", pwr, 0);
      chk("hook_on", hook_on, 0);
      chk("dct", dct_o, 2);
      chk("full", full_o, 0);
      cfg_load(13'h1001);
      line_set(12'h064, 0, 1'b1, 0);
      chk("sense_link_off", sense, 0);
      // no lock flag reaches this block, so the host waits the longest lock time
      wait_clk(LOCK_CYC);
      c2_write(8'h00);
      chk("id_fail", id_fail, 1);
      chk("link_up_bad", link_up, 0);
      chk("pwr_bad", pwr, 0);
      chk("sense_bad", sense, 0);
      c2_write(8'h01);
      chk("link_en_off", link_en, 0);
      @(posedge clk);
      id_good <= 1'b1;
      wait_clk(5);
      c2_write(8'h02);
      chk("cpo_off", cpo, 0);
      c2_write(8'h00);
      chk("link_up", link_up, 1);
      chk("pwr_on", pwr, 1);
      chk("cpo_on", cpo, 1);
      foreach (rows[k]) begin
         cfg_load(rows[k]);
         chk("country", {dct_o, ac_o, ohs_o, rt_o, rz_o, lim_o, vol_o}, rows[k][12:5]);
      end
      cfg_load(13'h1019);
      chk("full_hi", full_o, 1);
      chk("dc_imp", dcz_o, 1);
      chk("pin_low", pin_o, 1);
      foreach (vr[k]) begin
         line_set(vr[k], 0, 1'b1, 0);
         chk("volt_code", sense, ve[k]);
      end
      cfg_load(13'h1003);
      line_set(12'h064, 0, 1'b1, 5'h15);
      chk("monitor", sense, 5'h15);
      cfg_load(13'h1000);
      chk("no_select", sense, 0);
      cfg_load(13'h1005);
      chk("hook_on", hook_on, 1);
      foreach (cr[k]) begin
         line_set(12'h064, cr[k], 1'b1, 0);
         chk("curr_code", sense, ce[k]);
      end
      line_set(12'h064, 12'h000, 1'b0, 0);
      chk("dropout", drop, 1);
      chk("curr_none", sense, 5'h00);
      line_set(12'h064, 12'h03C, 1'b1, 0);
      chk("curr_15ma", sense, 5'h05);
      line_set(12'h064, 12'h0D8, 1'b1, 0);
      chk("no_dropout", drop, 0);
      cfg_load(13'h1845);
      chk("ctr21_edge", sense, 5'h12);
      line_set(12'h064, 12'h0D9, 1'b1, 0);
      chk("ctr21_ovl", sense, 5'h1F);
      cfg_load(13'h1001);
      chk("hook_off", hook_on, 0);
      c2_write(8'h01);
      chk("link_down", link_up, 0);
      chk("pwr_down", pwr, 0);
      chk("sense_down", sense, 0);
      close_out();
   end
endmodule // daa_line_side_config_monitor_tb
`default_nettype wire

// file: dlc_line_cfg.sv
// line-side configuration and line monitor: control 2, link bring-up with
// identity check, country settings and the five-bit sense readout.
// assumes software ports are on CLK; ID and loop-present come from pins.
`timescale 1ns/1ps
`default_nettype none
`include "dlc_map.svh"
module dlc_line_cfg #(
   parameter int RAW_W = 12,
   parameter logic [3:0] ID_EXPECT = `DLC_ID_EXPECT // arbitrary identity value
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CTRL2_WE,
   input wire logic [7:0] CTRL2_WDATA,
   input wire logic CFG_WE,
   input wire logic [1:0] DC_TERMINATION_SEL,
   input wire logic AC_IMPEDANCE_SELECT,
   input wire logic HOOK_SPEED_SEL,
   input wire logic RING_THRESHOLD_SEL,
   input wire logic RINGER_IMPEDANCE_SEL,
   input wire logic CURRENT_CAP_EN,
   input wire logic LOW_LINE_BOOST,
   input wire logic HIGH_LEVEL_SELECT,
   input wire logic PARALLEL_IMPEDANCE_SELECT,
   input wire logic HOOK_SEIZE,
   input wire logic ON_HOOK_MONITOR_EN,
   input wire logic VOLTAGE_REPORT_SELECT,
   input wire logic [3:0] LS_ID,
   input wire logic LOOP_PRESENT,
   input wire logic [RAW_W-1:0] VOLT_RAW,
   input wire logic [RAW_W-1:0] CURR_RAW,
   input wire logic [4:0] MON_DATA,
   output logic LINK_ENABLE,
   output logic LINK_UP,
   output logic ID_FAIL,
   output logic LINE_SIDE_PWR,
   output logic CALL_PROGRESS_OUT,
   output logic HOOKSWITCH_ON,
   output logic [1:0] DC_TERM_OUT,
   output logic AC_IMP_OUT,
   output logic HOOK_SPEED_OUT,
   output logic RING_THRESH_OUT,
   output logic RINGER_IMP_OUT,
   output logic CURRENT_CAP_OUT,
   output logic LOW_BOOST_OUT,
   output logic FULL_SCALE_HIGH,
   output logic DC_IMPEDANCE_HIGH,
   output logic TERM_PIN_LOW,
   output dlc_pkg::dlc_code_t LINE_SENSE_VALUE,
   output logic LINE_DROPOUT_FLAG
);
   import dlc_pkg::*;

   if (RAW_W < 12) begin : g_chk
      $error("dlc_line_cfg: raw sample width must cover the overload threshold");
   end

   logic [7:0] ctrl2, next_ctrl2;
   logic [1:0] dct, next_dct;
   logic act, hook_speed_sel, rt, rz, current_cap_en, low_line_boost, full, par, hook, on_hook_monitor_en, vrs;
   logic next_act, next_ohs, next_rt, next_rz, next_lim, next_vol;
   logic next_full, next_par, next_hook, next_on_hook_monitor_en, next_vrs;
   dlc_link_e link_state, next_link_state;
   logic [3:0] settle, next_settle;
   logic [3:0] id_meta, id_sync;
   logic [1:0] lp_sync;
   logic link_pd, up, cur_ovl;
   dlc_code_t volt_code, curr_code, sense_sel;

   assign link_pd = ctrl2[`DLC_C2_LPD];
   assign up = (link_state == LK_UP);

   // control 2 and country settings; only software strobes change them
   always_comb begin
      next_ctrl2 = ctrl2;
      if (CTRL2_WE) begin
         next_ctrl2 = CTRL2_WDATA;
      end
      {next_dct, next_act, next_ohs, next_rt, next_rz} = {dct, act, hook_speed_sel, rt, rz};
      {next_lim, next_vol, next_full, next_par} = {current_cap_en, low_line_boost, full, par};
      {next_hook, next_on_hook_monitor_en, next_vrs} = {hook, on_hook_monitor_en, vrs};
      if (CFG_WE) begin
         {next_dct, next_act, next_ohs} = {DC_TERMINATION_SEL, AC_IMPEDANCE_SELECT,
                                           HOOK_SPEED_SEL};
         {next_rt, next_rz, next_lim} = {RING_THRESHOLD_SEL, RINGER_IMPEDANCE_SEL,
                                         CURRENT_CAP_EN};
         {next_vol, next_full, next_par} = {LOW_LINE_BOOST, HIGH_LEVEL_SELECT,
                                            PARALLEL_IMPEDANCE_SELECT};
         {next_hook, next_on_hook_monitor_en, next_vrs} = {HOOK_SEIZE, ON_HOOK_MONITOR_EN,
                                             VOLTAGE_REPORT_SELECT};
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl2 <= `DLC_C2_RST;
         dct <= `DLC_DCT_RST;
         {act, hook_speed_sel, rt, rz, current_cap_en, low_line_boost} <= 6'h00;
         {full, par, hook, on_hook_monitor_en, vrs} <= 5'h00;
      end else begin
         ctrl2 <= next_ctrl2;
         dct <= next_dct;
         {act, hook_speed_sel, rt, rz, current_cap_en, low_line_boost} <= {next_act, next_ohs, next_rt, next_rz,
                                          next_lim, next_vol};
         {full, par, hook, on_hook_monitor_en, vrs} <= {next_full, next_par, next_hook, next_on_hook_monitor_en,
                                          next_vrs};
      end
   end

   // pin synchronisers; the first stage feeds only the second
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         id_meta <= 4'h0;
         id_sync <= 4'h0;
         lp_sync <= 2'h0;
      end else begin
         id_meta <= LS_ID;
         id_sync <= id_meta;
         lp_sync <= {lp_sync[0], LOOP_PRESENT};
      end
   end

   // link bring-up; the settle wait lets the synchronised id stop moving
   always_comb begin
      next_link_state = link_state;
      next_settle = settle;
      case (link_state)
         LK_OFF: begin
            next_settle = 4'h0;
            if (!link_pd) begin
               next_link_state = LK_CHECK;
            end
         end
         LK_CHECK: begin
            next_settle = settle + 4'h1;
            if (settle == `DLC_ID_SETTLE) begin
               next_link_state = (id_sync == ID_EXPECT) ? LK_UP : LK_FAIL;
            end
         end
         LK_UP: next_link_state = LK_UP;
         LK_FAIL: next_link_state = LK_FAIL; // dead until the link is powered down
         default: next_link_state = LK_OFF;
      endcase
      if (link_pd) begin
         next_link_state = LK_OFF;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         link_state <= LK_OFF;
         settle <= 4'h0;
      end else begin
         link_state <= next_link_state;
         settle <= next_settle;
      end
   end

   // overload code; threshold is lower in the current-limiting termination
   assign cur_ovl = (dct == `DLC_DCT_CTR21) ? (CURR_RAW > RAW_W'(`DLC_I_OVL_CTR)) :
                    (CURR_RAW > RAW_W'(`DLC_I_OVL));

   dlc_sense_quant #(.W(RAW_W), .STEP(`DLC_V_STEP), .LOW(`DLC_V_LOW),
                     .TOP(`DLC_CODE_MAX)) u_volt (
      .raw(VOLT_RAW),
      .force_max(1'b0),
      .code(volt_code)
   );

   dlc_sense_quant #(.W(RAW_W), .STEP(`DLC_I_STEP), .LOW(`DLC_I_MIN),
                     .TOP(`DLC_I_TOP)) u_curr (
      .raw(CURR_RAW),
      .force_max(cur_ovl),
      .code(curr_code)
   );

   always_comb begin
      if (!up) begin
         sense_sel = `DLC_CODE_ZERO; // nothing crosses a dead link
      end else if (hook) begin
         sense_sel = curr_code;
      end else if (on_hook_monitor_en) begin
         sense_sel = MON_DATA;
      end else if (vrs) begin
         sense_sel = volt_code;
      end else begin
         sense_sel = `DLC_CODE_ZERO;
      end
   end

   // line-side drive; power, call progress, hook, dropout and sense are gated by a good link so a bad part stays idle; country outputs are not
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         {LINK_ENABLE, LINK_UP, ID_FAIL, LINE_SIDE_PWR} <= 4'h0;
         {CALL_PROGRESS_OUT, HOOKSWITCH_ON} <= 2'h0;
         DC_TERM_OUT <= `DLC_DCT_RST;
         {AC_IMP_OUT, HOOK_SPEED_OUT, RING_THRESH_OUT, RINGER_IMP_OUT} <= 4'h0;
         {CURRENT_CAP_OUT, LOW_BOOST_OUT, FULL_SCALE_HIGH} <= 3'h0;
         {DC_IMPEDANCE_HIGH, TERM_PIN_LOW, LINE_DROPOUT_FLAG} <= 3'h0;
         LINE_SENSE_VALUE <= `DLC_CODE_ZERO;
      end else begin
         LINK_ENABLE <= !link_pd;
         LINK_UP <= up;
         ID_FAIL <= (link_state == LK_FAIL);
         LINE_SIDE_PWR <= up;
         CALL_PROGRESS_OUT <= up && !ctrl2[`DLC_C2_CPOFF];
         HOOKSWITCH_ON <= up && hook;
         DC_TERM_OUT <= dct;
         {AC_IMP_OUT, HOOK_SPEED_OUT, RING_THRESH_OUT, RINGER_IMP_OUT} <= {act, hook_speed_sel, rt, rz};
         {CURRENT_CAP_OUT, LOW_BOOST_OUT} <= {current_cap_en, low_line_boost};
         FULL_SCALE_HIGH <= full;
         DC_IMPEDANCE_HIGH <= par;
         TERM_PIN_LOW <= par;
         LINE_DROPOUT_FLAG <= up && hook && !lp_sync[1];
         LINE_SENSE_VALUE <= sense_sel;
      end
   end

   property p_safe_idle;
      @(posedge CLK) disable iff (!RST_N) !up |=> !HOOKSWITCH_ON && !LINE_SIDE_PWR;
   endproperty
   a_safe_idle: assert property (p_safe_idle) else $error("line driven without link");
   property p_link_off;
      @(posedge CLK) disable iff (!RST_N) link_pd |=> link_state == LK_OFF && !LINK_ENABLE;
   endproperty
   a_link_off: assert property (p_link_off) else $error("link not held off");
   property p_id_fail;
      @(posedge CLK) disable iff (!RST_N)
         (link_state == LK_CHECK && settle == `DLC_ID_SETTLE && id_sync != ID_EXPECT && !link_pd)
         |=> link_state == LK_FAIL ##1 ID_FAIL;
   endproperty
   a_id_fail: assert property (p_id_fail) else $error("bad identity not refused");
   // a power-down write is the only way out of the failed state
   property p_fail_stays;
      @(posedge CLK) disable iff (!RST_N)
         (link_state == LK_FAIL && !link_pd) |=> link_state == LK_FAIL;
   endproperty
   a_fail_stays: assert property (p_fail_stays) else $error("failed link woke up");
   property p_zero_write;
      @(posedge CLK) disable iff (!RST_N)
         (CTRL2_WE && CTRL2_WDATA == 8'h00) |=> ##6 (LINE_SIDE_PWR || ID_FAIL);
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("00H did not power up");
   property p_cp_out;
      @(posedge CLK) disable iff (!RST_N)
         (up && ctrl2 == 8'h00) |=> CALL_PROGRESS_OUT && LINE_SIDE_PWR;
   endproperty
   a_cp_out: assert property (p_cp_out) else $error("call progress not enabled");
   property p_full;
      @(posedge CLK) disable iff (!RST_N)
         (CFG_WE && HIGH_LEVEL_SELECT) |=> ##1 FULL_SCALE_HIGH;
   endproperty
   a_full: assert property (p_full) else $error("full scale not raised");

   property p_volt;
      @(posedge CLK) disable iff (!RST_N)
         (up && !hook && !on_hook_monitor_en && vrs) |=> LINE_SENSE_VALUE == $past(volt_code);
   endproperty
   a_volt: assert property (p_volt) else $error("voltage not reported");

   property p_volt_low;
      @(posedge CLK) disable iff (!RST_N)
         (up && !hook && !on_hook_monitor_en && vrs && VOLT_RAW < RAW_W'(`DLC_V_LOW)) |=> LINE_SENSE_VALUE == '0;
   endproperty
   a_volt_low: assert property (p_volt_low) else $error("low voltage not code 0");

   property p_overload;
      @(posedge CLK) disable iff (!RST_N) (up && hook && cur_ovl) |=> LINE_SENSE_VALUE == 5'h1F;
   endproperty
   a_overload: assert property (p_overload) else $error("overload not code 31");

   property p_hook;
      @(posedge CLK) disable iff (!RST_N) (up && $rose(hook)) |=> HOOKSWITCH_ON;
   endproperty
   a_hook: assert property (p_hook) else $error("hook seize ignored");

   property p_par;
      @(posedge CLK) disable iff (!RST_N) par |=> DC_IMPEDANCE_HIGH && TERM_PIN_LOW;
   endproperty
   a_par: assert property (p_par) else $error("parallel impedance not applied");

   c_link_up: cover property (@(posedge CLK) disable iff (!RST_N) $rose(LINK_UP));
   c_id_fail: cover property (@(posedge CLK) disable iff (!RST_N) $rose(ID_FAIL));
   c_offhook_ovl: cover property (@(posedge CLK) disable iff (!RST_N)
                                  HOOKSWITCH_ON && LINE_SENSE_VALUE == 5'h1F);
   c_dropout: cover property (@(posedge CLK) disable iff (!RST_N) LINE_DROPOUT_FLAG);
endmodule // dlc_line_cfg
`default_nettype wire

// file: dlc_line_model.sv
// line-side stand-in: identity pins, raw line samples, loop presence, monitor data.
// assumes the bench sets line conditions; every output launches on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module dlc_line_model #(
   parameter logic [3:0] ID_EXPECT = 4'h6 // arbitrary identity value
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic id_good,
   input wire logic [11:0] volt_q,
   input wire logic [11:0] curr_q,
   input wire logic loop_on,
   input wire logic [4:0] mon,
   output logic [3:0] ls_id,
   output logic [11:0] volt_raw,
   output logic [11:0] curr_raw,
   output logic loop_present,
   output logic [4:0] mon_data
);
   logic [33:0] st;
   logic [33:0] next_st;
   // identity answer: a foreign part shows the inverted code
   // samples in quarter units, never scaled here
   always_comb begin
      next_st = {id_good ? ID_EXPECT : ~ID_EXPECT, volt_q, curr_q, loop_on, mon};
   end
   // one register stage, as a real sampler would add
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= 34'h0;
      end else begin
         st <= next_st;
      end
   end
   assign {ls_id, volt_raw, curr_raw, loop_present, mon_data} = st;
endmodule // dlc_line_model
`default_nettype wire

// file: dlc_map.svh
// defines for the line-side configuration and monitor block: bit positions,
// reset values, thresholds and counts.
// assumes raw line samples arrive in quarter-volt and quarter-milliamp units.
//
// Contract
// - after power-up, defaults keep the line side unpowered and unable to draw current
// - writing 00H to control 2 powers the line side and enables call-progress output
// - isolated link is off by default; nothing passes until link_powerdown clears; the country outputs here follow their settings even with the link off
// - clearing link_powerdown starts an identity check; a failure leaves the block dead
// - high_level_select 1 gives 3.2 dBm full scale, 0 (default) gives -1 dBm
// - line_sense_value shows voltage, current or monitor data per the select bits
// - voltage reporting: 2.75 V per code, 87 V full scale, code 0 below 3 V
// - voltage is readable while on-hook with voltage_report_select set to 1; the code shows monitor data instead while on_hook_monitor_en is also set
// - parallel_impedance_select moves dc impedance from 50 to 800 ohm, lowers pin
// - hook_seize set takes the line off-hook; cleared returns it on-hook
// - off-hook, line_sense_value reports loop current at 3 mA per code
// - current code 0 is insufficient, 1 is minimum, 31 is overload
`ifndef DLC_MAP_SVH
`define DLC_MAP_SVH
`define DLC_C2_RST 8'h03
`define DLC_C2_LPD 0
`define DLC_C2_CPOFF 1
`define DLC_DCT_RST 2'h2
`define DLC_DCT_CTR21 2'h3
`define DLC_ID_SETTLE 4'h3
`define DLC_ID_EXPECT 4'hA
`define DLC_V_LOW 12'h00C
`define DLC_V_STEP 11
`define DLC_I_STEP 12
`define DLC_I_MIN 12'h00C
`define DLC_I_OVL 12'h230
`define DLC_I_OVL_CTR 12'h0D8
`define DLC_CODE_MAX 5'h1F
`define DLC_I_TOP 5'h1E
`define DLC_CODE_ZERO 5'h00
`define DLC_CODE_MIN 5'h01
`endif

// file: dlc_pkg.sv
// types shared by the line-side configuration block.
// assumes dlc_map.svh supplies the numeric constants.
`default_nettype none
package dlc_pkg;
   // link bring-up states, gray coded along off, check, up
   typedef enum logic [1:0] {
      LK_OFF = 2'b00,
      LK_CHECK = 2'b01,
      LK_UP = 2'b11,
      LK_FAIL = 2'b10
   } dlc_link_e;
   typedef logic [4:0] dlc_code_t;
endpackage
`default_nettype wire

// file: dlc_sense_quant.sv
// quantiser from a raw line sample to a five-bit sense code.
// assumes raw samples are on the same clock; output is combinational.
`timescale 1ns/1ps
`default_nettype none
`include "dlc_map.svh"
module dlc_sense_quant #(
   parameter int W = 12,
   parameter int STEP = 11,
   parameter logic [11:0] LOW = 12'h00C,
   parameter logic [4:0] TOP = 5'h1F
) (
   input wire logic [W-1:0] raw,
   input wire logic force_max,
   output logic [4:0] code
);
   import dlc_pkg::*;
   logic [W-1:0] quot;

   if (STEP < 1 || W < 6) begin : g_chk
      $error("dlc_sense_quant: step must be positive and width at least 6");
   end

   // below the floor reads zero; a forced overload reads the maximum code 31, not TOP
   always_comb begin
      quot = raw / W'(STEP);
      if (force_max) begin
         code = `DLC_CODE_MAX;
      end else if (raw < W'(LOW)) begin
         code = `DLC_CODE_ZERO;
      end else if (quot > W'(TOP)) begin
         code = TOP;
      end else if (quot == '0) begin
         code = `DLC_CODE_MIN; // first usable step never reads as zero
      end else begin
         code = quot[4:0];
      end
   end
endmodule // dlc_sense_quant
`default_nettype wire
